// File: inc/phy_diag_pkg.sv
/*
 * Shared constants for the management-controlled diagnostic block:
 * register offsets, field positions, reset values, frame codes,
 * state encodings and timing counts.
 * Assumes a 250 MHz system clock; used by src/phy_diag_irq_loopback_ctrl.sv.
 */
package phy_diag_pkg;

	// system clock
	localparam int unsigned MCLK_MHZ = 250;

	// register offsets on the management bus
	localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] REG_IRQ           = 5'h1B;
	localparam logic [4:0] REG_CABLE_TEST    = 5'h1D;
	localparam logic [4:0] REG_CTRL2         = 5'h1F;

	// basic control fields
	localparam int BC_LOOPBACK = 14;
	localparam int BC_SPEED    = 13;
	localparam int BC_ANEG     = 12;
	localparam int BC_DUPLEX   = 8;

	// cable test control/status fields
	localparam int CT_START    = 15;
	localparam int CT_RES_MSB  = 14;
	localparam int CT_RES_LSB  = 13;
	localparam int CT_DIST_MSB = 8;

	// second control fields
	localparam int C2_MDI_SEL   = 14;
	localparam int C2_AUTO_DIS  = 13;
	localparam int C2_IRQ_POL   = 9;
	localparam int C2_TX_DIS    = 3;
	localparam int C2_REMOTE_LB = 2;

	// reset values
	localparam logic [15:0] BASIC_CONTROL_RST = 16'h1000;
	localparam logic [15:0] CTRL2_RST         = 16'h4000;
	localparam logic [7:0]  IRQ_EN_RST        = 8'h00;

	// cable test result codes
	localparam logic [1:0] TDR_NORMAL  = 2'h0;
	localparam logic [1:0] TDR_OPEN    = 2'h1;
	localparam logic [1:0] TDR_SHORT   = 2'h2;
	localparam logic [1:0] TDR_INVALID = 2'h3;
	localparam logic [8:0] TDR_DIST_MAX = 9'h1FF;

	// management frame
	localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
	localparam logic [5:0] HDR_LAST      = 6'h0C;
	localparam logic [5:0] DATA_LAST     = 6'h0F;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [4:0] PHY_ADDR_BCAST = 5'h00;
	localparam logic [4:0] PHY_ADDR_HI    = 5'h03;
	localparam logic [1:0] STRAP_WAIT     = 2'h3;

	// timing: pulse is a least time (round up), quiet wait a longest time (round down)
	localparam int unsigned TDR_PULSE_NS  = 40;
	localparam int unsigned TDR_QUIET_NS  = 16000;
	localparam logic [11:0] TDR_PULSE_CYC = 12'((TDR_PULSE_NS * MCLK_MHZ + 999) / 1000);
	localparam logic [11:0] TDR_QUIET_CYC = 12'((TDR_QUIET_NS * MCLK_MHZ) / 1000);
	localparam logic [12:0] TDR_AGE_MAX   = 13'h1388;

	typedef enum logic [1:0] {
		M_PRE  = 2'b00,
		M_HDR  = 2'b01,
		M_TA   = 2'b10,
		M_DATA = 2'b11
	} mdio_state_e;

	typedef enum logic [1:0] {
		T_IDLE   = 2'b00,
		T_QUIET  = 2'b01,
		T_PULSE  = 2'b10,
		T_LISTEN = 2'b11
	} tdr_state_e;

endpackage

// File: src/phy_diag_irq_loopback_ctrl.sv
/*
 * Management register bank of a 10/100 transceiver: interrupt enables and
 * clear-on-read flags, pair assignment, local and remote loopback, cable test.
 * Assumes: i_mdc/i_mdio_in and analog status pins are asynchronous; the RMII
 * and line data paths run on i_ref_clk; i_irq_event and i_link_100fd come
 * from logic on i_mclk.
 */
`timescale 1ns/100ps

module phy_diag_irq_loopback_ctrl
	import phy_diag_pkg::*;
(
	// clocks and reset
	input  wire logic       i_mclk,
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// management bus and strap
	input  wire logic       i_mdc,
	input  wire logic       i_mdio_in,
	output logic            o_mdio_out,
	output logic            o_mdio_oe,
	input  wire logic       i_phyad_strap,
	// interrupt
	input  wire logic [7:0] i_irq_event,
	output logic            o_irq_out,
	// link mode
	input  wire logic       i_link_100fd,
	output logic            o_speed_100,
	output logic            o_full_duplex,
	output logic            o_aneg_en,
	// pair assignment
	input  wire logic       i_pair_a_energy,
	input  wire logic       i_pair_b_energy,
	output logic            o_mdix,
	// MAC side, on i_ref_clk
	input  wire logic       i_txen,
	input  wire logic [1:0] i_txd,
	output logic            o_crs_dv,
	output logic [1:0]      o_rxd,
	// line side, on i_ref_clk
	input  wire logic       i_line_rx_dv,
	input  wire logic [1:0] i_line_rxd,
	output logic            o_line_tx_en,
	output logic [1:0]      o_line_txd,
	// cable test front end
	output logic            o_tdr_quiet_req,
	output logic            o_tdr_pulse,
	input  wire logic       i_partner_quiet,
	input  wire logic       i_echo_seen,
	input  wire logic [1:0] i_echo_class
);

	logic [8:0]  async_in;
	logic [8:0]  sync1_ff;
	logic [8:0]  sync2_ff;
	logic        mdc_s, mdio_s, strap_s, pa_s, pb_s, quiet_s, echo_s;
	logic [1:0]  class_s;
	logic        mdc_prev_ff;
	logic        echo_prev_ff;
	logic        mdc_rise;
	logic        echo_rise;
	logic [1:0]  strap_cnt_ff;
	logic [4:0]  phy_addr_ff;
	mdio_state_e mst_ff;
	logic [5:0]  mcnt_ff;
	logic [11:0] hdr_ff;
	logic        rd_ff;
	logic        hit_ff;
	logic [15:0] sh_ff;
	logic [12:0] hdr_full;
	logic        hdr_ok;
	logic        rd_fire;
	logic        wr_fire;
	logic [4:0]  wr_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic [15:0] basic_ff;
	logic [15:0] ctrl2_ff;
	logic [7:0]  irq_en_ff;
	logic [7:0]  irq_st_ff;
	logic [7:0]  nxt_irq_st;
	logic        irq_act;
	tdr_state_e  tst_ff;
	logic [11:0] tcnt_ff;
	logic [1:0]  tdr_res_ff;
	logic [8:0]  tdr_dist_ff;
	logic        tdr_go;
	logic [2:0]  ctl_ff;
	logic [2:0]  rsync1_ff;
	logic [2:0]  rsync2_ff;
	logic [12:0] tdr_age_ff;
	logic [11:0] pulse_len_ff;

	// asynchronous pins pass two flops before anything reads them
	assign async_in = {i_mdc, i_mdio_in, i_phyad_strap, i_pair_a_energy, i_pair_b_energy,
	                   i_partner_quiet, i_echo_seen, i_echo_class};
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff <= 9'h000;
			sync2_ff <= 9'h000;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end
	assign {mdc_s, mdio_s, strap_s, pa_s, pb_s, quiet_s, echo_s, class_s} = sync2_ff;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mdc_prev_ff  <= 1'b0;
			echo_prev_ff <= 1'b0;
		end else begin
			mdc_prev_ff  <= mdc_s;
			echo_prev_ff <= echo_s;
		end
	end
	assign mdc_rise  = mdc_s & ~mdc_prev_ff;
	assign echo_rise = echo_s & ~echo_prev_ff;

	// strap is taken once the synchroniser has settled after reset release
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			strap_cnt_ff <= 2'h0;
			phy_addr_ff  <= PHY_ADDR_BCAST;
		end else if (strap_cnt_ff != STRAP_WAIT) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
			phy_addr_ff  <= strap_s ? PHY_ADDR_HI : PHY_ADDR_BCAST;
		end
	end

	// header as it stands once its last bit is sampled
	assign hdr_full = {hdr_ff, mdio_s};
	assign hdr_ok   = hdr_full[12] && (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE) &&
	                  (hdr_full[9:5] == phy_addr_ff || hdr_full[9:5] == PHY_ADDR_BCAST);
	assign rd_fire  = mdc_rise && mst_ff == M_HDR && mcnt_ff == HDR_LAST && hdr_ok &&
	                  hdr_full[11:10] == OP_READ;
	assign wr_fire  = mdc_rise && mst_ff == M_DATA && mcnt_ff == DATA_LAST && hit_ff && !rd_ff;
	assign wr_addr  = hdr_ff[4:0];
	assign wr_data  = {sh_ff[14:0], mdio_s};

	always_comb begin
		rd_data = 16'h0000;
		unique case (hdr_full[4:0])
			REG_BASIC_CONTROL: rd_data = basic_ff;
			REG_IRQ:           rd_data = {irq_en_ff, irq_st_ff};
			REG_CABLE_TEST:    rd_data = {tst_ff != T_IDLE, tdr_res_ff, 4'h0, tdr_dist_ff};
			REG_CTRL2:         rd_data = ctrl2_ff;
			default:           rd_data = 16'h0000;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mst_ff     <= M_PRE;
			mcnt_ff    <= 6'h00;
			hdr_ff     <= 12'h000;
			rd_ff      <= 1'b0;
			hit_ff     <= 1'b0;
			sh_ff      <= 16'h0000;
			o_mdio_out <= 1'b0;
			o_mdio_oe  <= 1'b0;
		end else if (mdc_rise) begin
			unique case (mst_ff)
				M_PRE: begin
					if (mdio_s) begin
						if (mcnt_ff != PREAMBLE_LEN)
							mcnt_ff <= mcnt_ff + 6'h01;
					end else if (mcnt_ff == PREAMBLE_LEN) begin
						mst_ff  <= M_HDR;
						mcnt_ff <= 6'h00;
					end else begin
						mcnt_ff <= 6'h00;
					end
				end
				M_HDR: begin
					hdr_ff  <= hdr_full[11:0];
					mcnt_ff <= mcnt_ff + 6'h01;
					if (mcnt_ff == HDR_LAST) begin
						mcnt_ff <= 6'h00;
						// a bad start bit drops the frame; a foreign address rides it out silently
						mst_ff  <= hdr_full[12] ? M_TA : M_PRE;
						rd_ff   <= hdr_full[11:10] == OP_READ;
						hit_ff  <= hdr_ok;
						sh_ff   <= rd_data;
					end
				end
				M_TA: begin
					if (mcnt_ff == 6'h00) begin
						mcnt_ff    <= 6'h01;
						o_mdio_oe  <= rd_ff && hit_ff;
						o_mdio_out <= 1'b0;
					end else begin
						mcnt_ff <= 6'h00;
						mst_ff  <= M_DATA;
						if (rd_ff) begin
							o_mdio_out <= sh_ff[15];
							sh_ff      <= {sh_ff[14:0], 1'b0};
						end
					end
				end
				M_DATA: begin
					mcnt_ff <= mcnt_ff + 6'h01;
					if (rd_ff) begin
						o_mdio_out <= sh_ff[15];
						sh_ff      <= {sh_ff[14:0], 1'b0};
					end else begin
						sh_ff <= wr_data;
					end
					if (mcnt_ff == DATA_LAST) begin
						mst_ff     <= M_PRE;
						mcnt_ff    <= 6'h00;
						o_mdio_oe  <= 1'b0;
						o_mdio_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// writable registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			basic_ff  <= BASIC_CONTROL_RST;
			ctrl2_ff  <= CTRL2_RST;
			irq_en_ff <= IRQ_EN_RST;
		end else if (wr_fire) begin
			if (wr_addr == REG_BASIC_CONTROL)
				basic_ff <= wr_data;
			if (wr_addr == REG_IRQ)
				irq_en_ff <= wr_data[15:8];
			if (wr_addr == REG_CTRL2)
				ctrl2_ff <= wr_data;
		end
	end
	assign o_speed_100   = basic_ff[BC_SPEED];
	assign o_full_duplex = basic_ff[BC_DUPLEX];
	assign o_aneg_en     = basic_ff[BC_ANEG];

	// flags record events; read clears them, a new event wins
	always_comb begin
		nxt_irq_st = irq_st_ff;
		if (rd_fire && hdr_full[4:0] == REG_IRQ)
			nxt_irq_st = 8'h00;
		nxt_irq_st = nxt_irq_st | i_irq_event;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			irq_st_ff <= 8'h00;
		else
			irq_st_ff <= nxt_irq_st;
	end

	assign irq_act = |(irq_st_ff & irq_en_ff);
	// polarity select; follows the gated flags
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_irq_out <= 1'b1;
		else
			o_irq_out <= ctrl2_ff[C2_IRQ_POL] ? irq_act : ~irq_act;
	end

	// auto detection unless disabled; forced select, 1 = straight
	// energy only on the second pair means partner crosses to us
	// o_mdix low: transmit first pair, receive second
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_mdix <= 1'b0;
		else if (ctrl2_ff[C2_AUTO_DIS])
			o_mdix <= ~ctrl2_ff[C2_MDI_SEL];
		else if (pb_s && !pa_s)
			o_mdix <= 1'b0;
		else if (pa_s && !pb_s)
			o_mdix <= 1'b1;
	end

	assign tdr_go = wr_fire && wr_addr == REG_CABLE_TEST && wr_data[CT_START] && tst_ff == T_IDLE;

	// quiet the partner, pulse, then time the reflection
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tst_ff      <= T_IDLE;
			tcnt_ff     <= 12'h000;
			tdr_res_ff  <= TDR_NORMAL;
			tdr_dist_ff <= 9'h000;
		end else begin
			unique case (tst_ff)
				T_IDLE: begin
					tcnt_ff <= 12'h000;
					if (tdr_go)
						tst_ff <= T_QUIET;
				end
				T_QUIET: begin
					tcnt_ff <= tcnt_ff + 12'h001;
					if (quiet_s) begin
						tst_ff  <= T_PULSE;
						tcnt_ff <= 12'h000;
					end else if (tcnt_ff == TDR_QUIET_CYC - 12'h001) begin
						tst_ff      <= T_IDLE;
						tdr_res_ff  <= TDR_INVALID;
						tdr_dist_ff <= 9'h000;
					end
				end
				T_PULSE: begin
					tcnt_ff <= tcnt_ff + 12'h001;
					if (tcnt_ff == TDR_PULSE_CYC - 12'h001) begin
						tst_ff  <= T_LISTEN;
						tcnt_ff <= 12'h000;
					end
				end
				T_LISTEN: begin
					tcnt_ff <= tcnt_ff + 12'h001;
					// result code; one count per cycle of flight
					if (echo_rise) begin
						tst_ff      <= T_IDLE;
						tdr_res_ff  <= class_s;
						tdr_dist_ff <= tcnt_ff[8:0];
					end else if (tcnt_ff[8:0] == TDR_DIST_MAX) begin
						// no reflection inside range reads as a sound cable
						tst_ff      <= T_IDLE;
						tdr_res_ff  <= TDR_NORMAL;
						tdr_dist_ff <= TDR_DIST_MAX;
					end
				end
			endcase
		end
	end
	assign o_tdr_quiet_req = tst_ff != T_IDLE;
	assign o_tdr_pulse     = tst_ff == T_PULSE;

	// loopback and transmit controls as levels, registered before crossing
	// local loopback needs autoneg off and full duplex, any speed
	// remote loopback only on a 100 full-duplex link
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			ctl_ff <= 3'h0;
		else
			ctl_ff <= {basic_ff[BC_LOOPBACK] & ~basic_ff[BC_ANEG] & basic_ff[BC_DUPLEX],
			           ctrl2_ff[C2_REMOTE_LB] & i_link_100fd,
			           ctrl2_ff[C2_TX_DIS]};
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rsync1_ff <= 3'h0;
			rsync2_ff <= 3'h0;
		end else begin
			rsync1_ff <= ctl_ff;
			rsync2_ff <= rsync1_ff;
		end
	end

	// link-side data path
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_crs_dv     <= 1'b0;
			o_rxd        <= 2'h0;
			o_line_tx_en <= 1'b0;
			o_line_txd   <= 2'h0;
		end else begin
			// looped data replaces line data; MAC sees its own frames
			o_crs_dv <= rsync2_ff[2] ? i_txen : i_line_rx_dv;
			o_rxd    <= rsync2_ff[2] ? i_txd : i_line_rxd;
			// transmitter off; line data echoed back
			if (rsync2_ff[0]) begin
				o_line_tx_en <= 1'b0;
				o_line_txd   <= 2'h0;
			end else if (rsync2_ff[1]) begin
				o_line_tx_en <= i_line_rx_dv;
				o_line_txd   <= i_line_rxd;
			end else begin
				o_line_tx_en <= i_txen;
				o_line_txd   <= i_txd;
			end
		end
	end

	// test age counter for the completion bound
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			tdr_age_ff <= 13'h0000;
		else if (tst_ff == T_IDLE)
			tdr_age_ff <= 13'h0000;
		else
			tdr_age_ff <= tdr_age_ff + 13'h0001;
	end

	// pulse length tracker
	// counted apart from the test counter so the width check does not trust its own source
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			pulse_len_ff <= 12'h000;
		else if (o_tdr_pulse)
			pulse_len_ff <= pulse_len_ff + 12'h001;
		else
			pulse_len_ff <= 12'h000;
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_irq_gated_level: assert property (
		##1 o_irq_out == ($past(ctrl2_ff[C2_IRQ_POL]) ? $past(irq_act) : !$past(irq_act)))
		else $error("interrupt pin does not follow enabled flags");
	a_flag_set_event: assert property (
		(i_irq_event != 8'h00) |=> ((irq_st_ff & $past(i_irq_event)) == $past(i_irq_event)))
		else $error("event did not set its flag");
	a_read_clears_flags: assert property (
		(rd_fire && hdr_full[4:0] == REG_IRQ) |=> irq_st_ff == $past(i_irq_event))
		else $error("interrupt register read did not clear flags");
	a_irq_idle_low_pol: assert property (
		(!ctrl2_ff[C2_IRQ_POL] && !irq_act) |=> o_irq_out)
		else $error("active-low interrupt asserted without cause");
	a_forced_pair: assert property (
		ctrl2_ff[C2_AUTO_DIS] |=> o_mdix == !$past(ctrl2_ff[C2_MDI_SEL]))
		else $error("forced pair assignment not applied");
	a_test_completes: assert property (
		tdr_age_ff < TDR_AGE_MAX)
		else $error("cable test did not finish in time");
	a_invalid_when_loud: assert property (
		(tst_ff == T_QUIET && !quiet_s && tcnt_ff == TDR_QUIET_CYC - 12'h001)
		|=> tst_ff == T_IDLE && tdr_res_ff == TDR_INVALID)
		else $error("unsilenced partner not reported as failed test");
	a_pulse_width: assert property (
		$fell(o_tdr_pulse) |-> pulse_len_ff == TDR_PULSE_CYC)
		else $error("test pulse width wrong");
	a_local_loop_rx: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		rsync2_ff[2] |=> o_crs_dv == $past(i_txen) && o_rxd == $past(i_txd))
		else $error("looped data not returned to the MAC");

	c_irq_read: cover property (rd_fire && hdr_full[4:0] == REG_IRQ);
	c_reg_write: cover property (wr_fire);
	c_test_done: cover property (tst_ff == T_LISTEN ##1 tst_ff == T_IDLE);
	c_irq_active: cover property (irq_act);

endmodule // phy_diag_irq_loopback_ctrl

// File: test/mdio_ctrl_model.sv
/*
 * Behavioural management-bus controller standing on the far side of the block.
 * Assumes the bench resolves the shared data wire with a pull-up.
 */
`timescale 1ns/100ps

module mdio_ctrl_model
	import phy_diag_pkg::*;
(
	// management bus
	output logic      o_mdc,
	output logic      o_mdio_oe,
	output logic      o_mdio_out,
	input  wire logic i_mdio
);
	// 80 ns period keeps the management clock well under its ceiling
	localparam realtime HALF = 40.0;

	initial begin
		o_mdc = 1'b0;
		o_mdio_oe = 1'b0;
		o_mdio_out = 1'b0;
	end

	// whole 64-bit frames, preamble included
	// clock stands low between frames; data changes only while the clock is low
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] adr,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFF_FFFF, 2'h1, op, phy, adr, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			o_mdio_oe = !(op == OP_READ && i < 18);
			o_mdio_out = bits[i];
			#HALF o_mdc = 1'b1;
			if (i < 16) rd = {rd[14:0], i_mdio};
			#HALF o_mdc = 1'b0;
		end
		o_mdio_oe = 1'b0;
	endtask
endmodule // mdio_ctrl_model

// File: test/phy_diag_irq_loopback_ctrl_tb_top.sv
/*
 * Self-checking bench: register access through management frames, interrupt,
 * pair assignment, loopback paths and cable test.
 * Assumes the controller model in test/mdio_ctrl_model.sv.
 */
`timescale 1ns/100ps

module phy_diag_irq_loopback_ctrl_tb_top
	import phy_diag_pkg::*;
;
	logic        i_mclk, i_ref_clk, i_rst;
	logic        ctl_mdc, ctl_oe, ctl_out, dut_out, dut_oe;
	logic [7:0]  i_irq_event;
	logic        o_irq_out, i_link_100fd, o_speed_100, o_full_duplex, o_aneg_en;
	logic        i_pair_a_energy, i_pair_b_energy, o_mdix;
	logic        i_txen, o_crs_dv, i_line_rx_dv, o_line_tx_en;
	logic [1:0]  i_txd, o_rxd, i_line_rxd, o_line_txd, i_echo_class;
	logic        o_tdr_quiet_req, o_tdr_pulse, i_partner_quiet, i_echo_seen;
	logic [15:0] rdata;
	int          errors, check_count, cycles;
	wire         mdio_wire = dut_oe ? dut_out : (ctl_oe ? ctl_out : 1'b1);

	always #2 i_mclk = ~i_mclk;
	// 160 ns link clock; its rising edges never meet a rising edge of the system clock
	always #80 i_ref_clk = ~i_ref_clk;

	mdio_ctrl_model u_mdio_ctrl_model (.o_mdc(ctl_mdc), .o_mdio_oe(ctl_oe), .o_mdio_out(ctl_out), .i_mdio(mdio_wire));

	phy_diag_irq_loopback_ctrl u_phy_diag_irq_loopback_ctrl (
		.i_mclk(i_mclk), .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mdc(ctl_mdc), .i_mdio_in(mdio_wire),
		.o_mdio_out(dut_out), .o_mdio_oe(dut_oe), .i_phyad_strap(1'b1), .i_irq_event(i_irq_event),
		.o_irq_out(o_irq_out), .i_link_100fd(i_link_100fd), .o_speed_100(o_speed_100),
		.o_full_duplex(o_full_duplex), .o_aneg_en(o_aneg_en), .i_pair_a_energy(i_pair_a_energy),
		.i_pair_b_energy(i_pair_b_energy), .o_mdix(o_mdix), .i_txen(i_txen), .i_txd(i_txd),
		.o_crs_dv(o_crs_dv), .o_rxd(o_rxd), .i_line_rx_dv(i_line_rx_dv), .i_line_rxd(i_line_rxd),
		.o_line_tx_en(o_line_tx_en), .o_line_txd(o_line_txd), .o_tdr_quiet_req(o_tdr_quiet_req),
		.o_tdr_pulse(o_tdr_pulse), .i_partner_quiet(i_partner_quiet), .i_echo_seen(i_echo_seen),
		.i_echo_class(i_echo_class));

	task automatic finish_test();
		$display("comparisons %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] adr, input logic [15:0] d);
		u_mdio_ctrl_model.frame(OP_WRITE, PHY_ADDR_HI, adr, d, rdata);
		repeat (8) @(posedge i_mclk);
	endtask

	task automatic rd(input logic [4:0] phy, input logic [4:0] adr);
		u_mdio_ctrl_model.frame(OP_READ, phy, adr, 16'h0000, rdata);
		repeat (8) @(posedge i_mclk);
	endtask

	task automatic rc(input logic [4:0] phy, input logic [4:0] adr, input logic [15:0] exp);
		rd(phy, adr);
		check(rdata, exp);
	endtask

	task automatic pulse(input logic [7:0] ev);
		i_irq_event <= ev;
		@(posedge i_mclk);
		i_irq_event <= 8'h00;
		repeat (4) @(posedge i_mclk);
	endtask

	// line input carries the inverse so a looped path is told apart from the line path
	task automatic ref_drv(input logic [1:0] d);
		@(posedge i_ref_clk);
		i_txen <= 1'b1;
		i_txd <= d;
		i_line_rx_dv <= 1'b1;
		i_line_rxd <= ~d;
		repeat (4) @(posedge i_ref_clk);
	endtask

	// front end: silence the partner, time the pulse, return an echo 40 cycles later
	task automatic echo_resp(input logic [1:0] cls);
		int n;
		n = 0;
		i_echo_class <= cls;
		for (int c = 0; c < 6000 && o_tdr_quiet_req !== 1'b1; c++) @(posedge i_mclk);
		i_partner_quiet <= 1'b1;
		for (int c = 0; c < 6000 && o_tdr_pulse !== 1'b1; c++) @(posedge i_mclk);
		while (o_tdr_pulse === 1'b1 && n < 50) begin
			@(posedge i_mclk);
			n++;
		end
		check(16'(n), 16'h000A);
		repeat (40) @(posedge i_mclk);
		i_echo_seen <= 1'b1;
	endtask

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		{i_mclk, i_ref_clk, i_irq_event, i_link_100fd, i_pair_a_energy, i_pair_b_energy} = '0;
		{i_txen, i_txd, i_line_rx_dv, i_line_rxd, i_partner_quiet, i_echo_seen, i_echo_class} = '0;
		{errors, check_count, cycles} = '0;
		i_rst = 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (10) @(posedge i_mclk);
		check(16'({o_irq_out, o_aneg_en, o_mdix}), 16'h0006);
		rc(PHY_ADDR_HI, REG_BASIC_CONTROL, 16'h1000);
		rc(PHY_ADDR_HI, REG_IRQ, 16'h0000);
		rc(PHY_ADDR_HI, REG_CABLE_TEST, 16'h0000);
		rc(PHY_ADDR_BCAST, REG_CTRL2, 16'h4000);
		rc(PHY_ADDR_HI, 5'h05, 16'h0000);
		rc(5'h01, REG_CTRL2, 16'hFFFF);
		wr(REG_IRQ, 16'h0100);
		pulse(8'h02);
		check(16'(o_irq_out), 16'h0001);
		pulse(8'h01);
		check(16'(o_irq_out), 16'h0000);
		rc(PHY_ADDR_HI, REG_IRQ, 16'h0103);
		check(16'(o_irq_out), 16'h0001);
		rc(PHY_ADDR_HI, REG_IRQ, 16'h0100);
		wr(REG_CTRL2, 16'h4200);
		check(16'(o_irq_out), 16'h0000);
		pulse(8'h01);
		check(16'(o_irq_out), 16'h0001);
		rc(PHY_ADDR_BCAST, REG_IRQ, 16'h0101);
		check(16'(o_irq_out), 16'h0000);
		wr(REG_CTRL2, 16'h6000);
		check(16'(o_mdix), 16'h0000);
		wr(REG_CTRL2, 16'h2000);
		check(16'(o_mdix), 16'h0001);
		i_pair_b_energy <= 1'b1;
		wr(REG_CTRL2, 16'h0000);
		check(16'(o_mdix), 16'h0000);
		i_pair_a_energy <= 1'b1;
		i_pair_b_energy <= 1'b0;
		repeat (8) @(posedge i_mclk);
		check(16'(o_mdix), 16'h0001);
		wr(REG_CTRL2, 16'h6000);
		for (int s = 0; s < 2; s++) begin
			wr(REG_BASIC_CONTROL, s ? 16'h6100 : 16'h4100);
			check(16'({o_speed_100, o_full_duplex, o_aneg_en}), s ? 16'h0006 : 16'h0002);
			ref_drv(2'(s + 1));
			check(16'({o_crs_dv, o_rxd}), 16'(s + 5));
			check(16'({o_line_tx_en, o_line_txd}), 16'(s + 5));
			@(posedge i_mclk);
		end
		wr(REG_CTRL2, 16'h6008);
		ref_drv(2'h3);
		check(16'({o_line_tx_en, o_line_txd}), 16'h0000);
		check(16'({o_crs_dv, o_rxd}), 16'h0007);
		@(posedge i_mclk);
		wr(REG_CTRL2, 16'h6000);
		wr(REG_BASIC_CONTROL, 16'h2100);
		i_link_100fd <= 1'b1;
		wr(REG_CTRL2, 16'h6004);
		ref_drv(2'h1);
		check(16'({o_line_tx_en, o_line_txd}), 16'h0006);
		@(posedge i_mclk);
		i_link_100fd <= 1'b0;
		ref_drv(2'h1);
		check(16'({o_line_tx_en, o_line_txd}), 16'h0005);
		check(16'({o_crs_dv, o_rxd}), 16'h0006);
		@(posedge i_mclk);
		// automatic pairs off, crossed pair chosen
		wr(REG_CTRL2, 16'h2000);
		for (int k = 0; k < 4; k++) begin
			fork
				wr(REG_CABLE_TEST, 16'h8000);
				if (k < 3) echo_resp(2'(k));
			join
			rdata = 16'h8000;
			// poll until the start bit clears
			for (int p = 0; p < 8 && rdata[CT_START] !== 1'b0; p++) rd(PHY_ADDR_HI, REG_CABLE_TEST);
			check(16'(rdata[15:13]), 16'(k));
			if (k == 3) check(16'(rdata[8:0]), 16'h0000);
			else check(16'(rdata[8:0] >= 9'h028 && rdata[8:0] <= 9'h02F), 16'h0001);
			i_partner_quiet <= 1'b0;
			i_echo_seen <= 1'b0;
			repeat (8) @(posedge i_mclk);
		end
		finish_test();
	end
endmodule // phy_diag_irq_loopback_ctrl_tb_top
